/* File: sim/spm_host.sv */
`timescale 1ns/10ps
module spm_host
    import spm_pkg::*;
(
    input  wire logic              mclk_i,
    input  wire logic [SPM_DW-1:0] rd_data_i,
    output spm_bus_t               bus_o
);
    initial
    begin
        bus_o = '0;
    end

    // Idle bus shows inverted leftovers, never the last request
    task automatic wr(input logic [SPM_AW-1:0] addr, input logic [SPM_DW-1:0] data);
        @(posedge mclk_i);
        bus_o.wr    <= 1'b1;
        bus_o.addr  <= addr;
        bus_o.wdata <= data;
        @(posedge mclk_i);
        bus_o.wr    <= 1'b0;
        bus_o.addr  <= ~addr;
        bus_o.wdata <= ~data;
    endtask

    // Read data stand only in the cycle after the strobe
    task automatic rd(input logic [SPM_AW-1:0] addr, output logic [SPM_DW-1:0] data);
        @(posedge mclk_i);
        bus_o.rd   <= 1'b1;
        bus_o.addr <= addr;
        @(posedge mclk_i);
        bus_o.rd   <= 1'b0;
        bus_o.addr <= ~addr;
        @(posedge mclk_i);
        data = rd_data_i;
    endtask

    task automatic assign_groups(input logic [7:0] groups);
        wr(SPM_OFS_GROUP, {24'h0, groups});
    endtask

    task automatic send_key(input logic [3:0] due);
        wr(SPM_OFS_KEY, {28'h0, due});
    endtask

    task automatic init_done();
        wr(SPM_OFS_CTRL, 32'h0000_0001);
    endtask
endmodule

/* File: sim/spm_top_tb.sv */
`timescale 1ns/10ps
module spm_top_tb
    import spm_pkg::*;
;
    typedef struct packed {
        logic [SPM_AW-1:0] addr;
        logic [SPM_DW-1:0] wdata;
        logic [SPM_DW-1:0] exp;
    } spm_row_t;

    localparam int        FL   = 4;
    localparam logic [3:0] EDDY = 4'h5;

    logic                 mclk_i;
    logic                 rst_n_i;
    logic [SPM_NCH-1:0]   pulse_i;
    logic [SPM_DW-1:0]    rd_data_o;
    logic                 fault_led_o;
    logic                 run_led_o;
    spm_bus_t             bus;
    logic [SPM_DW-1:0]    d;
    logic                 prev;
    int                   edges;
    int                   fails;
    int                   n_tests;
    int                   per  [SPM_NCH];
    int                   pcnt [SPM_NCH];
    spm_row_t             rows [4];

    spm_top #(
        .NCH        (SPM_NCH),
        .SAMPLE_CYC (200),
        .FLASH_CYC  (FL),
        .EDDY_MASK  (EDDY)
    ) spm_top_inst (
        .mclk_i      (mclk_i),
        .rst_n_i     (rst_n_i),
        .bus_i       (bus),
        .pulse_i     (pulse_i),
        .rd_data_o   (rd_data_o),
        .fault_led_o (fault_led_o),
        .run_led_o   (run_led_o)
    );

    spm_host spm_host_inst (
        .mclk_i    (mclk_i),
        .rd_data_i (rd_data_o),
        .bus_o     (bus)
    );

    initial
    begin
        mclk_i  = 1'b0;
        rst_n_i = 1'b0;
        pulse_i = '0;
        fails   = 0;
        n_tests = 0;
        for (int c = 0; c < SPM_NCH; c++)
        begin
            per[c]  = 2500;
            pcnt[c] = 0;
        end
    end

    always #4 mclk_i = ~mclk_i;

    // Square wave per channel; period zero holds the line low
    always @(posedge mclk_i)
    begin
        for (int c = 0; c < SPM_NCH; c++)
        begin
            pcnt[c] = (pcnt[c] + 1 >= per[c]) ? 0 : pcnt[c] + 1;
            pulse_i[c] <= (per[c] > 0) && (pcnt[c] < per[c] / 2);
        end
    end

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            fails++;
            $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
        end
    endtask

    // Settled filter at 50 kHz equivalent: within the shift dead band, no slope
    function automatic logic spd_ok(input logic [31:0] w);
        return (w[31:16] >= 16'hc34c) && (w[31:16] <= 16'hc350) && (w[15:0] === 16'h0000);
    endfunction

    task automatic final_report();
        $display("Checks %0d, mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask

    initial
    begin
        repeat (80000) @(posedge mclk_i);
        fails++;
        final_report();
    end

    initial
    begin
        rows[0] = '{SPM_OFS_RANGE, 32'h0000_00e4, 32'h0000_00e4};
        rows[1] = '{SPM_OFS_STAT,  32'hffff_ffff, {12'h0, EDDY, 16'h0003}};
        rows[2] = '{8'h40,         32'h1234_5678, 32'h0000_0000};
        rows[3] = '{SPM_OFS_CTRL,  32'h0000_0001, 32'h0000_0001};
        repeat (5) @(posedge mclk_i);
        rst_n_i <= 1'b1;
        @(posedge mclk_i);
        chk({30'h0, fault_led_o, run_led_o}, 32'h2);
        repeat (40) @(posedge mclk_i);
        chk({30'h0, fault_led_o, run_led_o}, 32'h2);
        for (int i = 0; i < 4; i++)
        begin
            spm_host_inst.wr(rows[i].addr, rows[i].wdata);
            spm_host_inst.rd(rows[i].addr, d);
            chk(d, rows[i].exp);
        end
        @(posedge mclk_i);
        chk(rd_data_o, 32'h0);
        chk({30'h0, fault_led_o, run_led_o}, 32'h1);
        spm_host_inst.rd(SPM_OFS_STAT, d);
        chk(d, {12'h0, EDDY, 16'h0007});
        spm_host_inst.assign_groups(8'h90);
        spm_host_inst.rd(SPM_OFS_GROUP, d);
        chk(d, 32'h0000_0090);

        // Same speed on every range: period count over prescale is constant
        repeat (52000) @(posedge mclk_i);
        spm_host_inst.send_key(4'h1);
        spm_host_inst.rd(SPM_OFS_DATA, d);
        chk({31'h0, spd_ok(d)}, 32'h1);
        spm_host_inst.rd(SPM_OFS_DATA + 8'h04, d);
        chk({31'h0, spd_ok(d)}, 32'h1);
        spm_host_inst.rd(SPM_OFS_DATA + 8'h08, d);
        chk(d, 32'h0);
        spm_host_inst.send_key(4'h6);
        spm_host_inst.rd(SPM_OFS_DATA + 8'h08, d);
        chk({31'h0, spd_ok(d)}, 32'h1);
        spm_host_inst.rd(SPM_OFS_DATA + 8'h0c, d);
        chk({31'h0, spd_ok(d)}, 32'h1);

        // Overspeed on channel 0 saturates and raises the speed code
        per[0] = 100;
        repeat (1500) @(posedge mclk_i);
        spm_host_inst.rd(SPM_OFS_STAT, d);
        chk({19'h0, d[12:8], 5'h0, d[2:0]}, {19'h0, SPM_CODE_SPEED, 8'h3});
        chk({31'h0, run_led_o}, 32'h0);
        edges = 0;
        prev  = fault_led_o;
        // One whole flash cycle, so the count holds at any phase
        repeat ((2 * 19 + 2 * SPM_FLASH_GAP) * FL)
        begin
            @(posedge mclk_i);
            if (fault_led_o && !prev)
                edges++;
            prev = fault_led_o;
        end
        chk(edges, 19);

        // Second reset in mid-run clears the sticky code
        per[0] = 2500;
        rst_n_i <= 1'b0;
        repeat (2) @(posedge mclk_i);
        chk({29'h0, fault_led_o, run_led_o, |rd_data_o}, 32'h4);
        rst_n_i <= 1'b1;
        repeat (40) @(posedge mclk_i);
        spm_host_inst.rd(SPM_OFS_STAT, d);
        chk(d, {12'h0, EDDY, 16'h0003});
        spm_host_inst.rd(SPM_OFS_RANGE, d);
        chk(d, {24'h0, SPM_RANGE_RST});
        spm_host_inst.rd(SPM_OFS_GROUP, d);
        chk(d, {24'h0, SPM_GROUP_RST});
        chk({30'h0, fault_led_o, run_led_o}, 32'h2);
        final_report();
    end
endmodule

/* File: src/spm_chan.sv */
`timescale 1ns/10ps
module spm_chan
    import spm_pkg::*;
(
    input  wire logic       mclk_i,
    input  wire logic       rst_n_i,
    input  wire logic       pulse_i,
    input  wire logic [1:0] range_i,
    output spm_meas_t       meas_o
);

    spm_cs_t q;
    spm_cs_t d;
    logic    rise;

    always_comb
    begin
        d    = q;
        rise = pulse_i & ~q.in_prev;
        d.in_prev = pulse_i;
        if (q.cnt != '1)
            d.cnt = q.cnt + 1'b1; // R2
        else
        begin
            d.period = '0; // R16
            d.valid  = 1'b0;
        end
        if (rise)
        begin
            if (q.edges >= spm_prescale(range_i) - 1'b1) // R1
            begin
                d.edges = '0;
                d.cnt   = '0;
                d.armed = 1'b1;
                if (q.armed && q.cnt != '1)
                begin
                    d.period = q.cnt + 1'b1; // R2
                    d.valid  = 1'b1;
                end
            end
            else
                d.edges = q.edges + 1'b1;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q <= '0;
        else
            q <= d;
    end

    assign meas_o.valid  = q.valid;
    assign meas_o.period = q.period;

endmodule

/* File: src/spm_pkg.sv */
package spm_pkg;

    // Geometry
    localparam int SPM_NCH     = 4;
    localparam int SPM_AW      = 8;
    localparam int SPM_DW      = 32;
    localparam int SPM_PW      = 28;
    localparam int SPM_SW      = 16;
    localparam int SPM_EW      = 4;

    // Timing
    localparam int SPM_CLK_HZ     = 125_000_000;
    localparam int SPM_CLK_MHZ    = 125;
    localparam int SPM_SAMPLE_US  = 100;
    localparam int SPM_SAMPLE_CYC = SPM_SAMPLE_US * SPM_CLK_MHZ;
    localparam int SPM_FLASH_MS   = 250;
    localparam int SPM_FLASH_CYC  = SPM_FLASH_MS * SPM_CLK_MHZ * 1000;
    localparam int SPM_FLASH_GAP  = 4;
    localparam int SPM_DIV_STEPS  = 32;

    // Register offsets
    localparam logic [SPM_AW-1:0] SPM_OFS_CTRL  = 8'h00;
    localparam logic [SPM_AW-1:0] SPM_OFS_STAT  = 8'h04;
    localparam logic [SPM_AW-1:0] SPM_OFS_RANGE = 8'h08;
    localparam logic [SPM_AW-1:0] SPM_OFS_GROUP = 8'h0c;
    localparam logic [SPM_AW-1:0] SPM_OFS_KEY   = 8'h10;
    localparam logic [SPM_AW-1:0] SPM_OFS_DATA  = 8'h20;

    // Field positions
    localparam int SPM_CTRL_INIT = 0;
    localparam int SPM_STAT_DONE = 0;
    localparam int SPM_STAT_PASS = 1;
    localparam int SPM_STAT_RUN  = 2;
    localparam int SPM_STAT_CODE = 8;
    localparam int SPM_STAT_TYPE = 16;

    // Reset values
    localparam logic [7:0] SPM_RANGE_RST = 8'h00;
    localparam logic [7:0] SPM_GROUP_RST = 8'h00;

    // Failure flash counts
    localparam logic [4:0] SPM_CODE_NONE  = 5'h00;
    localparam logic [4:0] SPM_CODE_LOGIC = 5'h05;
    localparam logic [4:0] SPM_CODE_SPEED = 5'h13;

    // Divider self-test vector
    localparam logic [31:0]       SPM_TEST_NUM = 32'h0001_0000;
    localparam logic [SPM_PW-1:0] SPM_TEST_DEN = 28'h000_0100;
    localparam logic [31:0]       SPM_TEST_QUO = 32'h0000_0100;

    localparam int SPM_FILT_SH = 2;

    typedef struct packed {
        logic              wr;
        logic              rd;
        logic [SPM_AW-1:0] addr;
        logic [SPM_DW-1:0] wdata;
    } spm_bus_t;

    typedef struct packed {
        logic              valid;
        logic [SPM_PW-1:0] period;
    } spm_meas_t;

    typedef struct packed {
        logic              in_prev;
        logic              armed;
        logic [SPM_EW-1:0] edges;
        logic [SPM_PW-1:0] cnt;
        logic [SPM_PW-1:0] period;
        logic              valid;
    } spm_cs_t;

    typedef enum logic [2:0] {
        SPM_ST_TEST,
        SPM_ST_IDLE,
        SPM_ST_LOAD,
        SPM_ST_DIV,
        SPM_ST_FILT
    } spm_st_t;

    function automatic logic [SPM_EW-1:0] spm_prescale(input logic [1:0] sel);
        spm_prescale = SPM_EW'(1) << sel;
    endfunction

endpackage

/* File: src/spm_top.sv */
// Chosen here: strobed register access and the address map.
`timescale 1ns/10ps
// Behaviour
// (R1) Divide each input pulse train by the prescale chosen by software range.
// (R2) Count reference clocks between prescaled edges to measure each period.
// (R3) Every 100 us capture all period counts and divide them into speed.
// (R4) Average speed every 100 us to improve resolution above 200 Hz.
// (R5) Produce a derivative beside each filtered speed.
// (R6) Copy newest speed and derivative to shared memory once per rate time.
// (R7) After reset fault indicator on; self-test runs; failure keeps it lit.
// (R8) On pass and init done, fault indicator off and run indicator on.
// (R9) Failures flash counts; 5 logic failure, 19 speed error.
// (R10) Host assigns each channel a rate group during initialisation.
// (R11) Host broadcasts a key naming rate groups due for update.
// (R12) Module schedules group updates from stored groups and received keys.
// (R13) Four channels, each factory fixed as magnetic pickup or eddy probe.
// (R14) Eddy channels measure down to 1 Hz input.
// (R15) Speed and derivative pair updated as one coherent word.
// (R16) Saturated period counter reports zero speed, never a stale value.
module spm_top
    import spm_pkg::*;
#(
    parameter int                   NCH        = SPM_NCH,
    parameter int                   SAMPLE_CYC = SPM_SAMPLE_CYC,
    parameter int                   FLASH_CYC  = SPM_FLASH_CYC,
    parameter logic [SPM_NCH-1:0]   EDDY_MASK  = 4'h0
)
(
    input  wire logic               mclk_i,
    input  wire logic               rst_n_i,
    input  spm_bus_t                bus_i,
    input  wire logic [NCH-1:0]     pulse_i,
    output logic      [SPM_DW-1:0]  rd_data_o,
    output logic                    fault_led_o,
    output logic                    run_led_o
);

    typedef struct packed {
        spm_st_t                      st;
        logic [23:0]                  tick_cnt;
        logic [1:0]                   ch;
        logic [5:0]                   bit_cnt;
        logic [31:0]                  num;
        logic [SPM_PW:0]              rem;
        logic [SPM_PW-1:0]            den;
        logic [31:0]                  quo;
        logic [SPM_NCH-1:0][SPM_PW-1:0] snap;
        logic [SPM_NCH-1:0][SPM_SW-1:0] avg;
        logic [SPM_NCH-1:0][SPM_SW-1:0] deriv;
        logic [SPM_NCH-1:0][SPM_DW-1:0] dpram;
        logic [SPM_NCH-1:0][1:0]      range;
        logic [SPM_NCH-1:0][1:0]      group;
        logic                         init_done;
        logic                         test_done;
        logic                         test_pass;
        logic [4:0]                   code;
        logic                         fault_led;
        logic                         run_led;
        logic [31:0]                  flash_tmr;
        logic [5:0]                   flash_idx;
        logic [SPM_DW-1:0]            rd_data;
    } spm_state_t;

    localparam spm_state_t RST_STATE = '{
        st        : SPM_ST_TEST,
        num       : SPM_TEST_NUM,
        den       : SPM_TEST_DEN,
        range     : SPM_RANGE_RST,
        group     : SPM_GROUP_RST,
        code      : SPM_CODE_NONE,
        fault_led : 1'b1,
        default   : '0
    };

    spm_state_t                q;
    spm_state_t                d;
    spm_meas_t  [SPM_NCH-1:0]  meas;

    logic                      tick;
    logic                      last_step;
    logic [SPM_PW:0]           rem_sh;
    logic [SPM_SW-1:0]         sp;
    logic signed [17:0]        diff;
    logic signed [17:0]        avg_sum;
    logic [SPM_SW-1:0]         avg_new;
    logic [5:0]                flash_end;
    logic [SPM_DW-1:0]         rd_val;

    genvar g;
    generate
        for (g = 0; g < SPM_NCH; g++)
        begin : gen_chan
            // Counter width covers a 1 Hz eddy input at the reference clock
            spm_chan u_chan ( // R13 R14
                .mclk_i  (mclk_i),
                .rst_n_i (rst_n_i),
                .pulse_i (pulse_i[g]),
                .range_i (q.range[g]),
                .meas_o  (meas[g])
            );
        end
    endgenerate

    assign tick      = (q.tick_cnt == 24'(SAMPLE_CYC - 1));
    assign last_step = (q.bit_cnt == 6'(SPM_DIV_STEPS - 1));

    always_comb
    begin
        d         = q;
        rem_sh    = '0;
        sp        = '0;
        diff      = '0;
        avg_sum   = '0;
        avg_new   = '0;
        flash_end = 6'({q.code, 1'b0}) + 6'(2 * SPM_FLASH_GAP - 1);
        rd_val    = '0;

        d.tick_cnt = tick ? '0 : q.tick_cnt + 1'b1;

        case (q.st)
            SPM_ST_TEST, SPM_ST_DIV:
            begin
                // One restoring step per clock
                rem_sh = {q.rem[SPM_PW-1:0], q.num[31]};
                d.num  = {q.num[30:0], 1'b0};
                if (rem_sh >= {1'b0, q.den})
                begin
                    d.rem = rem_sh - {1'b0, q.den};
                    d.quo = {q.quo[30:0], 1'b1};
                end
                else
                begin
                    d.rem = rem_sh;
                    d.quo = {q.quo[30:0], 1'b0};
                end
                d.bit_cnt = q.bit_cnt + 1'b1;
                if (last_step)
                begin
                    d.bit_cnt = '0;
                    if (q.st == SPM_ST_TEST)
                    begin
                        d.st        = SPM_ST_IDLE; // R7
                        d.test_done = 1'b1;
                        d.test_pass = (d.quo == SPM_TEST_QUO);
                        d.code      = (d.quo == SPM_TEST_QUO) ? SPM_CODE_NONE : SPM_CODE_LOGIC; // R9
                    end
                    else
                        d.st = SPM_ST_FILT;
                end
            end
            SPM_ST_IDLE:
            begin
                if (tick)
                begin
                    for (int c = 0; c < SPM_NCH; c++)
                        d.snap[c] = meas[c].valid ? meas[c].period : '0; // R3 R16
                    d.ch = '0;
                    d.st = SPM_ST_LOAD;
                end
            end
            SPM_ST_LOAD:
            begin
                d.num     = 32'(SPM_CLK_HZ) << q.range[q.ch]; // R1
                d.den     = q.snap[q.ch];
                d.rem     = '0;
                d.quo     = '0;
                d.bit_cnt = '0;
                d.st      = (q.snap[q.ch] == '0) ? SPM_ST_FILT : SPM_ST_DIV; // R16
            end
            SPM_ST_FILT:
            begin
                sp      = (q.quo[31:16] != '0) ? 16'hffff : q.quo[15:0]; // R3
                diff    = $signed({2'b00, sp}) - $signed({2'b00, q.avg[q.ch]});
                avg_sum = $signed({2'b00, q.avg[q.ch]}) + (diff >>> SPM_FILT_SH); // R4
                avg_new = avg_sum[15:0];
                d.avg[q.ch]   = avg_new;
                d.deriv[q.ch] = avg_new - q.avg[q.ch]; // R5
                if (q.quo[31:16] != '0 && q.code == SPM_CODE_NONE)
                    d.code = SPM_CODE_SPEED; // R9
                d.ch = q.ch + 1'b1;
                d.st = (q.ch == 2'(SPM_NCH - 1)) ? SPM_ST_IDLE : SPM_ST_LOAD;
            end
            default:
                d.st = SPM_ST_IDLE;
        endcase

        // Register writes
        if (bus_i.wr)
        begin
            case (bus_i.addr)
                SPM_OFS_CTRL:  d.init_done = bus_i.wdata[SPM_CTRL_INIT];
                SPM_OFS_RANGE: d.range     = bus_i.wdata[7:0];
                SPM_OFS_GROUP: d.group     = bus_i.wdata[7:0]; // R10
                SPM_OFS_KEY:
                begin
                    // Whole word per channel keeps the pair coherent
                    for (int c = 0; c < SPM_NCH; c++)
                        if (bus_i.wdata[q.group[c]])
                            d.dpram[c] = {q.avg[c], q.deriv[c]}; // R6 R11 R12 R15
                end
                default: ;
            endcase
        end

        // Read port, data valid only in the following cycle
        case (bus_i.addr)
            SPM_OFS_CTRL:  rd_val = 32'(q.init_done);
            SPM_OFS_STAT:
            begin
                rd_val[SPM_STAT_DONE]                  = q.test_done;
                rd_val[SPM_STAT_PASS]                  = q.test_pass;
                rd_val[SPM_STAT_RUN]                   = q.run_led;
                rd_val[SPM_STAT_CODE +: 5]             = q.code;
                rd_val[SPM_STAT_TYPE +: SPM_NCH]       = EDDY_MASK; // R13
            end
            SPM_OFS_RANGE: rd_val = 32'(q.range);
            SPM_OFS_GROUP: rd_val = 32'(q.group);
            default:
            begin
                for (int c = 0; c < SPM_NCH; c++)
                    if (bus_i.addr == SPM_OFS_DATA + 8'(4 * c))
                        rd_val = q.dpram[c];
            end
        endcase
        d.rd_data = bus_i.rd ? rd_val : '0;

        // Indicators
        d.flash_tmr = (q.flash_tmr == 32'(FLASH_CYC - 1)) ? '0 : q.flash_tmr + 1'b1;
        if (!q.test_done)
        begin
            d.fault_led = 1'b1; // R7
            d.run_led   = 1'b0;
            d.flash_tmr = '0;
            d.flash_idx = '0;
        end
        else if (q.code != SPM_CODE_NONE)
        begin
            d.run_led = 1'b0;
            if (q.flash_tmr == 32'(FLASH_CYC - 1))
            begin
                d.flash_idx = (q.flash_idx >= flash_end) ? '0 : q.flash_idx + 1'b1;
                d.fault_led = (d.flash_idx < 6'({q.code, 1'b0})) && !d.flash_idx[0]; // R9
            end
        end
        else if (q.init_done)
        begin
            d.fault_led = 1'b0; // R8
            d.run_led   = 1'b1;
        end
        else
        begin
            d.fault_led = 1'b1;
            d.run_led   = 1'b0;
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i)
    begin
        if (!rst_n_i)
            q <= RST_STATE;
        else
            q <= d;
    end

    assign rd_data_o   = q.rd_data;
    assign fault_led_o = q.fault_led;
    assign run_led_o   = q.run_led;

    a_fault_before_test: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R7
        !q.test_done |=> fault_led_o)
        else $error("fault indicator dark before self-test finished");

    a_run_needs_pass: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R8
        run_led_o |-> (!fault_led_o && $past(q.test_pass) && $past(q.init_done) &&
            $past(q.code) == SPM_CODE_NONE))
        else $error("run indicator lit without pass and init");

    a_run_on_init: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R8
        (q.test_done && q.init_done && q.code == SPM_CODE_NONE && $stable(q.init_done)) |=> run_led_o)
        else $error("run indicator not lit after init");

    a_tick_snaps: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R3
        (q.st == SPM_ST_IDLE && tick) |=> (q.st == SPM_ST_LOAD && q.ch == 2'd0 &&
            q.snap[0] == ($past(meas[0].valid) ? $past(meas[0].period) : '0)))
        else $error("sample tick did not capture periods");

    a_div_length: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R3
        (q.st == SPM_ST_LOAD && q.snap[q.ch] != '0) |-> ##33 (q.st == SPM_ST_FILT))
        else $error("division did not finish in 32 steps");

    a_zero_on_sat: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R16
        (q.st == SPM_ST_LOAD && q.snap[q.ch] == '0) |=> (q.st == SPM_ST_FILT && q.quo == '0))
        else $error("saturated channel not reported as zero speed");

    a_deriv_pair: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R5
        (q.st == SPM_ST_FILT && q.ch == 2'd0) |=> (q.deriv[0] == q.avg[0] - $past(q.avg[0])))
        else $error("derivative does not track filtered speed");

    a_key_copy: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R6 R15
        (bus_i.wr && bus_i.addr == SPM_OFS_KEY && bus_i.wdata[q.group[0]])
            |=> (q.dpram[0] == {$past(q.avg[0]), $past(q.deriv[0])}))
        else $error("key did not copy coherent pair");

    a_read_data: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R6
        (bus_i.rd && bus_i.addr == SPM_OFS_DATA) |=> (rd_data_o == $past(q.dpram[0])))
        else $error("shared memory read returned wrong word");

    a_speed_code: assert property (@(posedge mclk_i) disable iff (!rst_n_i) // R9
        (q.st == SPM_ST_FILT && q.quo[31:16] != '0 && q.code == SPM_CODE_NONE)
            |=> (q.code == SPM_CODE_SPEED))
        else $error("speed overflow did not raise flash count 19");

endmodule
